/* psc_defines.svh */
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// word selector values in bits 1:0
`define PSC_SEL_LSB        0
`define PSC_SEL_FBOUT      2'h1
`define PSC_SEL_PWR        2'h2

// feedback/output word field positions
`define PSC_FB_DELAY_LSB   12
`define PSC_MUX_LSB        15
`define PSC_PUMP_DIR_BIT   30
`define PSC_EXT_RES_BIT    31

// power-management word field positions
`define PSC_HOLD_BIT       2
`define PSC_PD_N_BIT       3
`define PSC_DIVRST_N_BIT   4
`define PSC_BG_EN_BIT      5
`define PSC_LOCKW_LSB      6

// power-up values
`define PSC_RST_FB_DELAY   3'h0
`define PSC_RST_OUT0_DIVIDER_SELECT       3'h0
`define PSC_RST_OUT1_DIVIDER_SELECT       3'h1
`define PSC_RST_OUT2_DIVIDER_SELECT       3'h2
`define PSC_RST_OUT3_DIVIDER_SELECT       3'h3
`define PSC_RST_OUT4_DIVIDER_SELECT       3'h3
`define PSC_RST_PUMP_DIR   1'h1
`define PSC_RST_EXT_RES    1'h0
`define PSC_RST_HOLD       1'h0
`define PSC_RST_PD_N       1'h1
`define PSC_RST_DIVRST_N   1'h1
`define PSC_RST_BG_EN      1'h1
`define PSC_RST_LOCKW      2'h0

// analog step sizes, for reference by consumers
`define PSC_DELAY_STEP_PS  150
`define PSC_LOCKW_MIN_PS   1200

`endif

/* psc_pkg.sv */
package psc_pkg;

   typedef logic [2:0] psc_div_sel_t;

   // feedback/output word contents
   typedef struct packed {
      logic                  ext_resistor_enable;
      logic                  pump_direction;
      psc_div_sel_t [4:0]    out_divider_select;
      logic [2:0]            feedback_delay;
   } psc_fbout_t;

   // power-management word contents
   typedef struct packed {
      logic [1:0]            lock_window;
      logic                  bandgap_enable;
      logic                  divider_reset_n;
      logic                  power_down_n;
      logic                  hold_enable;
   } psc_pwr_t;

   // whole block state
   typedef struct packed {
      psc_fbout_t            fbout;
      psc_pwr_t              pwr;
   } psc_state_t;

endpackage : psc_pkg

/* psc_config_words.sv */
`timescale 1ns/10ps
`include "psc_defines.svh"

module psc_config_words
   #(
      parameter int WORD_W = 32
   )
   (
      // clock and reset
      input  wire logic            sys_clk,
      input  wire logic            rst,
      // latched serial word from the shift front end
      input  wire logic [31:0]     word_data,
      input  wire logic            word_load,
      // configuration out to the analog side
      output psc_pkg::psc_fbout_t  fbout_cfg,
      output psc_pkg::psc_pwr_t    pwr_cfg,
      // derived controls
      output logic                 hold_active,
      output logic                 current_sources_off,
      output logic                 dividers_in_reset,
      output logic                 outputs_tristate,
      output logic                 pump_hold
   );
   import psc_pkg::*;

   // word layout handled here, selector in bits 1:0 of every word:
   //   feedback/output word, selector 01
   //     31     external resistor enable
   //     30     charge-pump correction sense
   //     29:27  divider select, output 4
   //     26:24  divider select, output 3
   //     23:21  divider select, output 2
   //     20:18  divider select, output 1
   //     17:15  divider select, output 0
   //     14:12  feedback-path delay code
   //     11:2   feedback divider value, kept by another block and dropped here
   //   power-management word, selector 10
   //     31:8   reserved, dropped
   //     7:6    lock-detect window, bit 6 the lsb
   //     5      bandgap enable
   //     4      divider reset, active low
   //     3      power down, active low
   //     2      charge-pump hold
   //   selectors 00 and 11 belong to words kept elsewhere; this block ignores them

   // the field map is fixed at 32 bits
   if (WORD_W != 32)
   begin : g_bad_width
      $error("psc_config_words: WORD_W must be 32");
   end

   // whole configuration as one struct, registered in one place
   psc_state_t state_q;
   psc_state_t state_d;

   // route decode, used by the update and the assertions
   function automatic logic is_sel(input logic [31:0] w, input logic [1:0] sel);
      is_sel = (w[`PSC_SEL_LSB +: 2] == sel);
   endfunction : is_sel

   // next state: only a word with a known selector lands; others are other words' business
   always_comb
   begin
      state_d = state_q;
      if (word_load && is_sel(word_data, `PSC_SEL_FBOUT))
      begin
         // bits 11:2 carry the feedback divider value, which another block keeps
         state_d.fbout.feedback_delay      = word_data[`PSC_FB_DELAY_LSB +: 3];
         for (int i = 0; i < 5; i++)
         begin
            state_d.fbout.out_divider_select[i] = word_data[`PSC_MUX_LSB + 3*i +: 3];
         end
         state_d.fbout.pump_direction      = word_data[`PSC_PUMP_DIR_BIT];
         state_d.fbout.ext_resistor_enable = word_data[`PSC_EXT_RES_BIT];
      end
      else if (word_load && is_sel(word_data, `PSC_SEL_PWR))
      begin
         // reserved bits 31:8 are dropped
         state_d.pwr.hold_enable     = word_data[`PSC_HOLD_BIT];
         state_d.pwr.power_down_n    = word_data[`PSC_PD_N_BIT];
         state_d.pwr.divider_reset_n = word_data[`PSC_DIVRST_N_BIT];
         state_d.pwr.bandgap_enable  = word_data[`PSC_BG_EN_BIT];
         state_d.pwr.lock_window     = word_data[`PSC_LOCKW_LSB +: 2];
      end
   end

   // state register with power-up values
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         // each field spelled out so its power-up value sits beside its rule
         state_q.fbout.feedback_delay        <= `PSC_RST_FB_DELAY;
         state_q.fbout.out_divider_select[0] <= `PSC_RST_OUT0_DIVIDER_SELECT;
         state_q.fbout.out_divider_select[1] <= `PSC_RST_OUT1_DIVIDER_SELECT;
         state_q.fbout.out_divider_select[2] <= `PSC_RST_OUT2_DIVIDER_SELECT;
         state_q.fbout.out_divider_select[3] <= `PSC_RST_OUT3_DIVIDER_SELECT;
         state_q.fbout.out_divider_select[4] <= `PSC_RST_OUT4_DIVIDER_SELECT;
         state_q.fbout.pump_direction        <= `PSC_RST_PUMP_DIR;
         state_q.fbout.ext_resistor_enable   <= `PSC_RST_EXT_RES;
         state_q.pwr.hold_enable             <= `PSC_RST_HOLD;
         state_q.pwr.power_down_n            <= `PSC_RST_PD_N;
         state_q.pwr.divider_reset_n         <= `PSC_RST_DIVRST_N;
         state_q.pwr.bandgap_enable          <= `PSC_RST_BG_EN;
         state_q.pwr.lock_window             <= `PSC_RST_LOCKW;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // outputs straight from flops; power-down overrides pump_hold (not hold_active) and the divider reset
   assign fbout_cfg           = state_q.fbout;
   assign pwr_cfg             = state_q.pwr;
   assign hold_active         = state_q.pwr.hold_enable;
   assign pump_hold           = state_q.pwr.hold_enable & state_q.pwr.power_down_n;
   assign current_sources_off = ~state_q.pwr.power_down_n;
   assign outputs_tristate    = ~state_q.pwr.power_down_n;
   assign dividers_in_reset   = ~state_q.pwr.power_down_n | ~state_q.pwr.divider_reset_n;
   // the words are write-only: nothing reads them back, so a host that loses track must rewrite both
   // a refused selector raises no flag; the host learns of a bad word only from the analog side
   // the 250 MHz limit is not checked here; a bad divider choice is the host's to avoid

   // checks: each load check looks one edge after the routed word, once the flops have taken it
   // power word fields and their effects
   a_pwr_load_hold : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && is_sel(word_data, `PSC_SEL_PWR) |=> hold_active == $past(word_data[`PSC_HOLD_BIT]))
      else $error("hold bit not loaded");
   a_pd_tristate : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && is_sel(word_data, `PSC_SEL_PWR) && !word_data[`PSC_PD_N_BIT]
      |=> outputs_tristate && current_sources_off && dividers_in_reset && !pump_hold)
      else $error("power-down effects missing");
   a_pd_release : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && is_sel(word_data, `PSC_SEL_PWR) && word_data[`PSC_PD_N_BIT]
      |=> !outputs_tristate && !current_sources_off)
      else $error("outputs still off after power-up word");
   a_hold_gate : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && is_sel(word_data, `PSC_SEL_PWR) && word_data[`PSC_HOLD_BIT] && word_data[`PSC_PD_N_BIT]
      |=> hold_active && pump_hold)
      else $error("hold not reaching the pump");
   a_divrst_holds : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && is_sel(word_data, `PSC_SEL_PWR) && !word_data[`PSC_DIVRST_N_BIT] |=> dividers_in_reset)
      else $error("divider reset not applied");
   a_divrst_release : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && is_sel(word_data, `PSC_SEL_PWR) && word_data[`PSC_PD_N_BIT] && word_data[`PSC_DIVRST_N_BIT]
      |=> !dividers_in_reset)
      else $error("dividers held in reset without cause");
   a_bg_load : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && is_sel(word_data, `PSC_SEL_PWR) |=> pwr_cfg.bandgap_enable == $past(word_data[`PSC_BG_EN_BIT]))
      else $error("bandgap bit not loaded");
   a_lockw_load : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && is_sel(word_data, `PSC_SEL_PWR) |=> pwr_cfg.lock_window == $past(word_data[7:6]))
      else $error("lock window not loaded");

   // feedback/output word fields
   a_dir_load : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && is_sel(word_data, `PSC_SEL_FBOUT) |=> fbout_cfg.pump_direction == $past(word_data[30]))
      else $error("pump direction not loaded");
   a_ext_resistor_enable_load : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && is_sel(word_data, `PSC_SEL_FBOUT) |=> fbout_cfg.ext_resistor_enable == $past(word_data[31]))
      else $error("resistor enable not loaded");
   a_delay_load : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && is_sel(word_data, `PSC_SEL_FBOUT) |=> fbout_cfg.feedback_delay == $past(word_data[14:12]))
      else $error("feedback delay not loaded");
   a_mux_load : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && is_sel(word_data, `PSC_SEL_FBOUT) |=> fbout_cfg.out_divider_select == $past(word_data[29:15]))
      else $error("divider selects not loaded");

   // one check per output lane, so a failure points at the lane that slipped
   for (genvar g = 0; g < 5; g++)
   begin : g_lane_chk
      a_lane_load : assert property (@(posedge sys_clk) disable iff (rst)
         word_load && is_sel(word_data, `PSC_SEL_FBOUT)
         |=> fbout_cfg.out_divider_select[g] == $past(word_data[`PSC_MUX_LSB + 3*g +: 3]))
         else $error("divider select lane not loaded");
   end

   // routing: a word only lands in the word its selector names
   a_route_keep : assert property (@(posedge sys_clk) disable iff (rst)
      !(word_load && is_sel(word_data, `PSC_SEL_PWR)) |=> $stable(pwr_cfg))
      else $error("power word changed without a routed load");
   a_route_fb_keep : assert property (@(posedge sys_clk) disable iff (rst)
      !(word_load && is_sel(word_data, `PSC_SEL_FBOUT)) |=> $stable(fbout_cfg))
      else $error("feedback word changed without a routed load");
   a_bad_sel_keep : assert property (@(posedge sys_clk) disable iff (rst)
      word_load && (is_sel(word_data, 2'h0) || is_sel(word_data, 2'h3))
      |=> $stable(pwr_cfg) && $stable(fbout_cfg))
      else $error("unrouted word changed the configuration");

   // power-up values, checked on every edge while reset is held
   // no disable here: these are the only checks that must run inside reset
   a_pwr_reset : assert property (@(posedge sys_clk)
      rst |-> pwr_cfg == {`PSC_RST_LOCKW, `PSC_RST_BG_EN, `PSC_RST_DIVRST_N, `PSC_RST_PD_N, `PSC_RST_HOLD})
      else $error("power word not at power-up value");
   a_fb_reset : assert property (@(posedge sys_clk)
      rst |-> fbout_cfg == {`PSC_RST_EXT_RES, `PSC_RST_PUMP_DIR, `PSC_RST_OUT4_DIVIDER_SELECT, `PSC_RST_OUT3_DIVIDER_SELECT, `PSC_RST_OUT2_DIVIDER_SELECT,
                            `PSC_RST_OUT1_DIVIDER_SELECT, `PSC_RST_OUT0_DIVIDER_SELECT, `PSC_RST_FB_DELAY})
      else $error("feedback word not at power-up value");

   // main scenarios
   c_pwr_down : cover property (@(posedge sys_clk) disable iff (rst) $fell(pwr_cfg.power_down_n));
   c_fb_load  : cover property (@(posedge sys_clk) disable iff (rst) word_load && is_sel(word_data, `PSC_SEL_FBOUT));
   c_lockw3   : cover property (@(posedge sys_clk) disable iff (rst) pwr_cfg.lock_window == 2'h3);
   c_hold_on  : cover property (@(posedge sys_clk) disable iff (rst) $rose(pump_hold));
   c_bad_sel  : cover property (@(posedge sys_clk) disable iff (rst) word_load && is_sel(word_data, 2'h3));

endmodule : psc_config_words

/* psc_host_model.sv */
`timescale 1ns/10ps
module psc_host_model
   (
      // clock
      input  wire logic  sys_clk,
      // latched word toward the block
      output logic [31:0] word_data,
      output logic        word_load
   );
   initial
   begin
      word_data = 32'h0;
      word_load = 1'b0;
   end
   // one whole word per call, held one cycle; the bus shows the inverse once released
   task automatic send(input logic [31:0] w);
      @(negedge sys_clk);
      word_data = w; // caller picks selector and keeps divider codes legal
      word_load = 1'b1;
      @(negedge sys_clk);
      word_load = 1'b0;
      word_data = ~w;
   endtask : send
endmodule : psc_host_model

/* pll_synth_config_words_bench.sv */
`timescale 1ns/10ps
module pll_synth_config_words_bench;
   import psc_pkg::*;
   logic        sys_clk;
   logic        rst;
   logic [31:0] word_data;
   logic        word_load;
   psc_fbout_t  fbout_cfg;
   psc_pwr_t    pwr_cfg;
   logic        hold_active, current_sources_off, dividers_in_reset, outputs_tristate, pump_hold;
   int          num_errors = 0;
   int          cmp_count = 0;
   psc_config_words DUT (.sys_clk(sys_clk), .rst(rst), .word_data(word_data), .word_load(word_load),
      .fbout_cfg(fbout_cfg), .pwr_cfg(pwr_cfg), .hold_active(hold_active),
      .current_sources_off(current_sources_off), .dividers_in_reset(dividers_in_reset),
      .outputs_tristate(outputs_tristate), .pump_hold(pump_hold));
   psc_host_model host (.sys_clk(sys_clk), .word_data(word_data), .word_load(word_load));
   // free-running clock, 10 ns period
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic close_out();
      if (num_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out
   // values up to 22 bits compared four-state
   task automatic chk(input logic [21:0] got, input logic [21:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_reset_values();
      chk(fbout_cfg, {1'b0, 1'b1, 3'h3, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0});
      chk(pwr_cfg, 6'h0E);
      chk({hold_active, pump_hold, current_sources_off, outputs_tristate, dividers_in_reset}, 5'h00);
   endtask : chk_reset_values
   // every power field combination, reserved bits at A5A5A5
   task automatic scen_power_words();
      logic [5:0] p;
      logic [4:0] d;
      for (int i = 0; i < 64; i++)
      begin
         p = i[5:0];
         d = {p[0], p[0] & p[1], ~p[1], ~p[1], ~p[1] | ~p[2]};
         host.send({24'hA5A5A5, p, 2'h2});
         chk(pwr_cfg, p);
         chk({hold_active, pump_hold, current_sources_off, outputs_tristate, dividers_in_reset}, d);
      end
   endtask : scen_power_words
   // feedback word fields, junk in the unused middle bits, every delay code
   task automatic scen_feedback_word();
      for (int i = 0; i < 8; i++)
      begin
         host.send({1'b1, 1'b0, 3'h4, 3'h1, 3'h7, 3'h6, 3'h5, i[2:0], 10'h3FF, 2'h1});
         chk(fbout_cfg, {1'b1, 1'b0, 3'h4, 3'h1, 3'h7, 3'h6, 3'h5, i[2:0]});
      end
   endtask : scen_feedback_word
   // selectors 00 and 11 must leave both words alone
   task automatic scen_bad_selector();
      host.send(32'h0);
      host.send(32'h3);
      chk(pwr_cfg, 7'h3F);
      chk(fbout_cfg, {1'b1, 1'b0, 3'h4, 3'h1, 3'h7, 3'h6, 3'h5, 3'h7});
   endtask : scen_bad_selector
   // second reset in mid-run restores power-up values, then the first word after it lands
   task automatic scen_mid_reset();
      @(negedge sys_clk);
      rst = 1'b1;
      @(negedge sys_clk);
      chk_reset_values();
      rst = 1'b0;
      host.send({24'h000000, 6'h15, 2'h2});
      chk(pwr_cfg, 6'h15);
      chk({hold_active, pump_hold, current_sources_off, outputs_tristate, dividers_in_reset}, 5'h17);
      chk(fbout_cfg, {1'b0, 1'b1, 3'h3, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0});
   endtask : scen_mid_reset
   initial
   begin
      rst = 1'b1;
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      chk_reset_values();
      scen_power_words();
      scen_feedback_word();
      scen_bad_selector();
      scen_mid_reset();
      close_out();
   end
   // hang guard
   initial
   begin
      #200000;
      num_errors++;
      close_out();
   end
endmodule : pll_synth_config_words_bench
